/* File: verilog/adc_conversion_sequencer.sv */
// conversion sequencer with apb registers and analog core handshake
`include "adc_seq_defs.svh"
module adc_conversion_sequencer
  import adc_seq_pkg::*;
#(
  parameter int CHANNELS = 11
) (
  input  wire logic                clock,
  input  wire logic                reset,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic                     pready,
  output logic      [31:0]         prdata,
  output logic                     pslverr,
  output logic                     core_start,
  output logic      [3:0]          core_channel,
  output logic      [CHANNELS-1:0] core_select,
  output logic                     core_eight_bit,
  output logic                     core_compare,
  output logic                     core_offset_comp,
  output logic      [7:0]          core_reference,
  input  wire logic [11:0]         core_result,
  input  wire logic                core_compare_out,
  output logic                     done_irq,
  output logic                     busy
);
  typedef struct packed {
    seq_state_t state;
    op_kind_t   op;
    logic [7:0] control;
    logic [7:0] mode;
    logic [7:0] low;
    logic [7:0] high;
    logic [1:0] tail;
    logic       start_pulse;
    logic [1:0] cmp_sync;
    logic [11:0] res_s1;
    logic [11:0] res_s2;
  } state_t;

  state_t     cur_reg;
  state_t     cur_next;
  logic       wr_en;
  logic       rd_en;
  logic       addr_ok;
  logic [2:0] div_code;
  logic [7:0] base_ticks;
  logic       timer_load;
  logic       timer_expired;

  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && penable && !pwrite;
  assign addr_ok = (paddr == `ADC_CONTROL_ADDR) || (paddr == `ADC_MODE_ADDR)
                 || (paddr == `RESULT_LOW_ADDR) || (paddr == `RESULT_HIGH_ADDR);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  assign div_code = {cur_reg.low[`LOW_DIVHI_BIT],
                     cur_reg.mode[`MODE_DIV_MSB:`MODE_DIV_LSB]}; // [RULE2]

  always_comb begin
    case (cur_reg.op)
      op_conv12:  base_ticks = `TICKS_12BIT;   // [RULE17]
      op_conv8:   base_ticks = `TICKS_8BIT;
      op_compare: base_ticks = `TICKS_COMPARE; // [RULE11]
      default:    base_ticks = `TICKS_12BIT;
    endcase
  end

  adc_interval_timer u_timer (
    .clock      (clock),
    .reset      (reset),
    .load       (timer_load),
    .div_code   (div_code),
    .base_ticks (base_ticks),
    .expired    (timer_expired)
  );

  adc_channel_decode #(
    .CHANNELS (CHANNELS)
  ) u_decode (
    .code          (cur_reg.control[`CTRL_CHAN_MSB:`CTRL_CHAN_LSB]),
    .select_onehot (core_select)
  );

  always_comb begin
    cur_next = cur_reg;
    cur_next.start_pulse = 1'b0;
    cur_next.cmp_sync = {cur_reg.cmp_sync[0], core_compare_out};
    cur_next.res_s1 = core_result;
    cur_next.res_s2 = cur_reg.res_s1;
    timer_load = 1'b0;

    // register writes
    if (wr_en) begin
      case (paddr)
        `ADC_CONTROL_ADDR: begin
          cur_next.control = pwdata[7:0];
          // software writes can only clear the done flag, never set it
          cur_next.control[`CTRL_DONE_BIT] =
            cur_reg.control[`CTRL_DONE_BIT] && pwdata[`CTRL_DONE_BIT]; // [RULE7]
        end
        `ADC_MODE_ADDR:    cur_next.mode = pwdata[7:0];
        `RESULT_LOW_ADDR:  cur_next.low  = pwdata[7:0];
        `RESULT_HIGH_ADDR: cur_next.high = pwdata[7:0]; // [RULE12]
        default: ;
      endcase
    end

    case (cur_reg.state)
      seq_idle: begin
        if (cur_next.control[`CTRL_START_BIT]) begin // [RULE4]
          if (cur_next.control[`CTRL_CMP_BIT]) begin
            cur_next.op = op_compare;
          end else if (cur_next.mode[`MODE_RESOLUTION_SELECT_BIT]) begin
            cur_next.op = op_conv8; // [RULE20]
          end else begin
            cur_next.op = op_conv12; // [RULE1]
          end
          cur_next.start_pulse = 1'b1; // [RULE21]
          cur_next.state = seq_run;
        end
      end
      seq_run: begin
        if (cur_reg.start_pulse) begin
          timer_load = 1'b1;
        end
        if (!cur_next.control[`CTRL_START_BIT]) begin
          cur_next.state = seq_idle; // [RULE14]
        end else if (timer_expired) begin
          cur_next.tail = `TAIL_CYCLES - 8'd1 > 8'd0 ? 2'd1 : 2'd0;
          cur_next.state = seq_tail;
        end
      end
      seq_tail: begin
        if (!cur_next.control[`CTRL_START_BIT]) begin
          cur_next.state = seq_idle; // [RULE14]
        end else if (cur_reg.tail != 2'd0) begin
          cur_next.tail = cur_reg.tail - 2'd1;
        end else begin
          // completion: latch results, set done, drop start
          cur_next.state = seq_idle;
          cur_next.control[`CTRL_DONE_BIT]  = 1'b1; // [RULE5] [RULE7]
          cur_next.control[`CTRL_START_BIT] = 1'b0; // [RULE5]
          case (cur_reg.op)
            op_compare: begin
              cur_next.low[7] = cur_reg.cmp_sync[1]; // [RULE13] [RULE22]
            end
            op_conv8: begin
              cur_next.high = cur_reg.res_s2[11:4]; // [RULE20] [RULE22]
            end
            default: begin
              cur_next.high = cur_reg.res_s2[11:4]; // [RULE18] [RULE9]
              cur_next.low[7:4] = cur_reg.res_s2[3:0]; // [RULE18] [RULE22]
            end
          endcase
        end
      end
      default: cur_next.state = seq_idle;
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cur_reg <= '0; // [RULE15]
      cur_reg.state <= seq_idle;
      cur_reg.op <= op_conv12;
      cur_reg.control <= `REG_RESET;
      cur_reg.mode <= `REG_RESET;
      cur_reg.low <= `REG_RESET;
      cur_reg.high <= `REG_RESET;
    end else begin
      cur_reg <= cur_next;
    end
  end

  always_comb begin
    prdata = 32'h0000_0000;
    if (rd_en) begin
      case (paddr)
        `ADC_CONTROL_ADDR: prdata[7:0] = cur_reg.control; // [RULE6]
        `ADC_MODE_ADDR:    prdata[7:0] = cur_reg.mode;
        `RESULT_LOW_ADDR:  prdata[7:0] = cur_reg.low; // [RULE9]
        `RESULT_HIGH_ADDR: prdata[7:0] = cur_reg.high;
        default:           prdata = 32'h0000_0000;
      endcase
    end
  end

  assign core_start       = cur_reg.start_pulse; // [RULE21]
  assign core_channel     = cur_reg.control[`CTRL_CHAN_MSB:`CTRL_CHAN_LSB];
  assign core_eight_bit   = (cur_reg.op == op_conv8);
  assign core_compare     = cur_reg.control[`CTRL_CMP_BIT];
  assign core_offset_comp = cur_reg.mode[`MODE_ADJ_BIT];
  assign core_reference   = cur_reg.high; // [RULE12]
  assign done_irq = cur_reg.control[`CTRL_DONE_BIT]
                  && cur_reg.control[`CTRL_IE_BIT]; // [RULE8]
  assign busy = cur_reg.control[`CTRL_START_BIT]; // [RULE16]
endmodule : adc_conversion_sequencer

/* File: inc/adc_seq_defs.svh */
// offsets, field positions, reset values and timing counts of the sequencer
// Notes on behaviour
// [RULE1] resolution_select zero gives 12-bit conversion
// [RULE2] divider bits pick ratio; 1/01 is 1/32
// [RULE3] channel_select 0001 routes analog_input_1
// [RULE4] writing start one launches an operation
// [RULE5] completion sets done flag, clears start together
// [RULE6] software polls done flag for completion
// [RULE7] done flag stays until software writes zero
// [RULE8] done with irq enable raises interrupt request
// [RULE9] result split high/low; read high first
// [RULE10] comparator needs cmp one, adj one, resolution_select zero; code starts a compare on cmp one alone
// [RULE11] comparison lasts 28/ratio plus two cycles
// [RULE12] high byte holds the comparison reference
// [RULE13] compare outcome in low byte bit 7
// [RULE14] clearing start mid-operation aborts it
// [RULE15] reset clears start and halts converter
// [RULE16] no low-power modes while start is set
// [RULE17] 12-bit conversion lasts 52/ratio plus two
// [RULE18] 12-bit: high byte upper, low nibble bits 7:4
// [RULE19] codes 0000 to 1010 select eleven inputs
// [RULE20] 8-bit mode writes only high byte
// [RULE21] start pulse, count interval, latch, then done
// [RULE22] results written only at completion cycle
`ifndef ADC_SEQ_DEFS_SVH
`define ADC_SEQ_DEFS_SVH
`define ADC_CONTROL_ADDR   12'h000
`define ADC_MODE_ADDR      12'h004
`define RESULT_LOW_ADDR    12'h008
`define RESULT_HIGH_ADDR   12'h00C
`define CTRL_CHAN_MSB      7
`define CTRL_CHAN_LSB      4
`define CTRL_CMP_BIT       3
`define CTRL_START_BIT     2
`define CTRL_DONE_BIT      1
`define CTRL_IE_BIT        0
`define MODE_RESOLUTION_SELECT_BIT     6
`define MODE_ADJ_BIT       2
`define MODE_DIV_MSB       1
`define MODE_DIV_LSB       0
`define LOW_DIVHI_BIT      0
`define REG_RESET          8'h00
`define MAX_CHANNEL        4'hA
`define TICKS_12BIT        8'd52
`define TICKS_8BIT         8'd32
`define TICKS_COMPARE      8'd28
`define TAIL_CYCLES        8'd2
`endif

/* File: inc/adc_seq_pkg.sv */
// types of the conversion sequencer
package adc_seq_pkg;
  typedef enum logic [1:0] {
    seq_idle,
    seq_run,
    seq_tail
  } seq_state_t;

  typedef enum logic [1:0] {
    op_conv12,
    op_conv8,
    op_compare
  } op_kind_t;
endpackage : adc_seq_pkg

/* File: verilog/adc_channel_decode.sv */
// one-hot channel decode towards the input multiplexer
module adc_channel_decode
  import adc_seq_pkg::*;
#(
  parameter int CHANNELS = 11
) (
  input  wire logic [3:0]          code,
  output logic      [CHANNELS-1:0] select_onehot
);
  genvar i;
  generate
    for (i = 0; i < CHANNELS; i++) begin : g_ch
      assign select_onehot[i] = (code == 4'(i)); // [RULE3] [RULE19]
    end
  endgenerate
endmodule : adc_channel_decode

/* File: verilog/adc_interval_timer.sv */
// division-scaled interval counter for one operation
module adc_interval_timer
  import adc_seq_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       load,
  input  wire logic [2:0] div_code,
  input  wire logic [7:0] base_ticks,
  output logic            expired
);
  logic [7:0] count_reg;
  logic [7:0] count_next;
  logic [7:0] load_value;

  // base/ratio; at least one prescaled tick
  always_comb begin
    load_value = base_ticks >> div_code; // [RULE2]
    if (load_value == 8'h00) begin
      load_value = 8'h01;
    end
    count_next = count_reg;
    if (load) begin
      count_next = load_value;
    end else if (count_reg != 8'h00) begin
      count_next = count_reg - 8'h01;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      count_reg <= 8'h00;
    end else begin
      count_reg <= count_next;
    end
  end

  assign expired = (count_reg == 8'h01) && !load;
endmodule : adc_interval_timer

/* File: test/adc_core_model.sv */
// behavioural analog core and input multiplexer
module adc_core_model (
  input  wire logic [3:0]  core_channel,
  input  wire logic [7:0]  core_reference,
  output logic      [11:0] core_result,
  output logic             core_compare_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // each input level is its channel code over 5A
  assign core_result = {core_channel, 8'h5A};
  assign core_compare_out = core_reference < core_result[11:4];
endmodule : adc_core_model

/* File: test/adc_conversion_sequencer_chk.sv */
// port assertions of the conversion sequencer
module adc_conversion_sequencer_chk #(parameter int CHANNELS = 11) (
  input wire logic                clock,
  input wire logic                reset,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [11:0]         paddr,
  input wire logic [31:0]         pwdata,
  input wire logic [31:0]         prdata,
  input wire logic                core_start,
  input wire logic [3:0]          core_channel,
  input wire logic [CHANNELS-1:0] core_select,
  input wire logic                done_irq,
  input wire logic                busy
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  logic ctl_wr;
  assign ctl_wr = psel && penable && pwrite && paddr == 12'h000;
  start_pulse_a: assert property (ctl_wr && pwdata[2] && !busy
    |-> ##[1:2] core_start) else $error("no start pulse");
  pulse_once_a: assert property (core_start |=> !core_start)
    else $error("start pulse too long");
  done_stop_a: assert property ($rose(done_irq) && $past(busy)
    |-> !busy) else $error("start left set at done");
  done_hold_a: assert property (done_irq && !ctl_wr |=> done_irq)
    else $error("done dropped without clear");
  select_map_a: assert property (core_select ==
    ((core_channel <= 4'hA) ? CHANNELS'(1) << core_channel : '0))
    else $error("bad select");
  abort_stop_a: assert property (ctl_wr && !pwdata[2] |=> !busy)
    else $error("abort ignored");
  rst_clear_a: assert property ($fell(reset)
    |-> !busy && !core_start) else $error("busy after reset");
  read_zero_a: assert property (psel && penable && !pwrite
    |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
  cover property (core_start);
  cover property ($rose(done_irq));
  cover property (ctl_wr && !pwdata[2] && busy);
endmodule : adc_conversion_sequencer_chk

bind adc_conversion_sequencer adc_conversion_sequencer_chk
  #(.CHANNELS(CHANNELS)) u_chk (.*);

/* File: test/adc_conversion_sequencer_test.sv */
// self-checking bench of the conversion sequencer
module adc_conversion_sequencer_test import adc_seq_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] mode_tab [3] = '{8'h00, 8'h40, 8'h04};
  localparam logic [7:0] ctl_tab [3] = '{8'h14, 8'h14, 8'h1C};
  localparam int ticks [3] = '{52, 32, 28};
  logic        clock, reset, psel, penable, pwrite, pready, pslverr, err;
  logic        core_compare_out, done_irq, busy;
  logic        core_eight_bit, core_compare, core_offset_comp;
  logic [11:0] paddr, core_result;
  logic [31:0] pwdata, prdata, v;
  logic [7:0]  core_reference;
  logic [3:0]  core_channel;
  int          bad_count = 0, checked = 0, cyc = 0;

  adc_conversion_sequencer u_dut (.clock(clock), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .core_start(), .core_channel(core_channel), .core_select(),
    .core_eight_bit(core_eight_bit), .core_compare(core_compare),
    .core_offset_comp(core_offset_comp),
    .core_reference(core_reference), .core_result(core_result),
    .core_compare_out(core_compare_out), .done_irq(done_irq), .busy(busy));
  adc_core_model u_core (.core_channel(core_channel),
    .core_reference(core_reference), .core_result(core_result),
    .core_compare_out(core_compare_out));

  initial begin
    clock = 1'h0;
    forever #25 clock = ~clock;
  end

  task automatic summarize();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize

  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // setup, access until pready, release, one idle cycle
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    do @(posedge clock); while (pready !== 1'h1);
    r = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clock);
  endtask : apb

  // start, count cycles until idle, check and clear done
  task automatic conv(input logic [7:0] c, output int n);
    apb(1'h1, 12'h000, {24'h0, c}, v);
    n = 0;
    while (busy !== 1'h0) begin
      @(posedge clock);
      n++;
    end
    apb(1'h0, 12'h000, 32'h0, v);
    chk(v, {24'h0, c & 8'hFB | 8'h02});
    chk(32'(done_irq), 32'(c[0]));
    apb(1'h1, 12'h000, {24'h0, c & 8'hF8}, v);
    chk(32'(done_irq), 32'h0);
  endtask : conv

  initial begin
    int n0, n5, i;
    {psel, penable, pwrite, paddr, pwdata, reset} = '0;
    reset = 1'h1;
    repeat (5) @(posedge clock);
    reset <= 1'h0;
    for (i = 0; i < 20; i += 4) begin
      apb(1'h0, 12'(i), 32'h0, v);
      chk(v, 32'h0);
      chk(32'(err), 32'(i == 16));
    end
    $display("test reset_values done");
    for (i = 0; i < 3; i++) begin
      apb(1'h1, 12'h004, {24'h0, mode_tab[i]}, v);
      apb(1'h1, 12'h008, 32'h0, v);
      conv(ctl_tab[i], n0);
      apb(1'h1, 12'h004, {24'h0, mode_tab[i] | 8'h01}, v);
      apb(1'h1, 12'h008, 32'h1, v);
      conv(ctl_tab[i], n5);
      chk(32'(n0 - n5), 32'(ticks[i] - 1));
    end
    $display("test intervals done");
    apb(1'h1, 12'h004, 32'h01, v);
    apb(1'h1, 12'h008, 32'h01, v);
    conv(8'h15, n0);
    chk(32'(core_eight_bit), 32'h0);
    apb(1'h0, 12'h00C, 32'h0, v);
    chk(v, 32'h15);
    apb(1'h0, 12'h008, 32'h0, v);
    chk(v, 32'hA1);
    apb(1'h1, 12'h004, 32'h41, v);
    conv(8'h24, n0);
    chk(32'(core_eight_bit), 32'h1);
    apb(1'h0, 12'h00C, 32'h0, v);
    chk(v, 32'h25);
    apb(1'h0, 12'h008, 32'h0, v);
    chk(v, 32'hA1);
    $display("test results done");
    apb(1'h1, 12'h004, 32'h05, v);
    for (i = 0; i < 2; i++) begin
      apb(1'h1, 12'h00C, i ? 32'h20 : 32'h30, v);
      conv(8'h2C, n0);
      apb(1'h0, 12'h008, 32'h0, v);
      chk(v, {24'h0, i[0], 7'h21});
      chk(32'({core_compare, core_offset_comp}), 32'h3);
    end
    $display("test compare done");
    apb(1'h1, 12'h004, 32'h00, v);
    apb(1'h1, 12'h008, 32'h00, v);
    apb(1'h1, 12'h000, 32'h14, v);
    repeat (5) @(posedge clock);
    apb(1'h1, 12'h000, 32'h10, v);
    apb(1'h0, 12'h000, 32'h0, v);
    chk(v, 32'h10);
    apb(1'h0, 12'h00C, 32'h0, v);
    chk(v, 32'h20);
    apb(1'h1, 12'h000, 32'h14, v);
    repeat (3) @(posedge clock);
    reset <= 1'h1;
    @(posedge clock);
    reset <= 1'h0;
    @(negedge clock);
    chk(32'(busy), 32'h0);
    $display("test abort done");
    summarize();
  end
endmodule : adc_conversion_sequencer_test
